// ### verilog/wwd_params.svh
// Timing and width constants for the window supervisor
`ifndef WWD_PARAMS_SVH
`define WWD_PARAMS_SVH
`define WWD_CLK_HZ 20000000
`define WWD_CYC0_US 10
`define WWD_CYC1_US 100
`define WWD_CYC0_CLKS ((`WWD_CYC0_US * (`WWD_CLK_HZ / 1000000)))
`define WWD_CYC1_CLKS ((`WWD_CYC1_US * (`WWD_CLK_HZ / 1000000)))
`define WWD_LOW_MS 600
`define WWD_LOW_CLKS (`WWD_LOW_MS * (`WWD_CLK_HZ / 1000))
`define WWD_FILT_US 400
`define WWD_FILT_CLKS (`WWD_FILT_US * (`WWD_CLK_HZ / 1000000))
`define WWD_IRQ_LOW_US 100
`define WWD_IRQ_LOW_CLKS (`WWD_IRQ_LOW_US * (`WWD_CLK_HZ / 1000000))
`define WWD_IRQ_TO_US 300
`define WWD_IRQ_TO_CLKS (`WWD_IRQ_TO_US * (`WWD_CLK_HZ / 1000000))
`define WWD_IRQ_HIGH_US 300
`define WWD_IRQ_HIGH_CLKS (`WWD_IRQ_HIGH_US * (`WWD_CLK_HZ / 1000000))
`define WWD_CNT_W 8
`define WWD_ERR_W 6
`define WWD_ERR_MAX 6'h3f
`define WWD_OW_RST 8'h01
`define WWD_CW_RST 8'h01
`define WWD_THR_RST 6'h08
`endif

// ### verilog/wwd_pkg.sv
// Types for the window supervisor
package wwd_pkg;
	typedef enum logic [2:0] {
		WWD_ST_OFF = 3'b001,
		WWD_ST_OPEN = 3'b010,
		WWD_ST_CLOSED = 3'b100
	} wwd_state_t;
	typedef enum logic [2:0] {
		WWD_IRQ_IDLE = 3'b001,
		WWD_IRQ_LOW = 3'b010,
		WWD_IRQ_HIGH = 3'b100
	} wwd_irq_state_t;
endpackage

// ### verilog/wwd_irq_line.sv
// Active-low interrupt line with minimum low/high times and a time-out
`timescale 1ns/1ps
`include "wwd_params.svh"
module wwd_irq_line
	import wwd_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic srst_in,
	// Flag state
	input wire logic new_flag_in,
	input wire logic flags_pending_in,
	// Pin and miss pulse
	output logic irq_n_out,
	output logic missed_out
);
	wwd_irq_state_t st_r;
	logic [12:0] tmr_r;
	logic defer_r;

	// Line sequencing: low on new flag, held a minimum, released on clear or time-out
	always_ff @(posedge clk_in) begin
		missed_out <= 1'b0;
		if (srst_in) begin
			st_r <= WWD_IRQ_IDLE;
			tmr_r <= 13'h0000;
			irq_n_out <= 1'b1;
			defer_r <= 1'b0;
		end else begin
			case (st_r)
				WWD_IRQ_IDLE: begin
					if (new_flag_in || defer_r) begin
						st_r <= WWD_IRQ_LOW;
						irq_n_out <= 1'b0;
						tmr_r <= 13'h0000;
						defer_r <= 1'b0;
					end
				end
				WWD_IRQ_LOW: begin
					tmr_r <= tmr_r + 13'h0001;
					if (tmr_r >= 13'(`WWD_IRQ_TO_CLKS - 1)) begin
						st_r <= WWD_IRQ_HIGH;
						irq_n_out <= 1'b1;
						missed_out <= 1'b1;
						tmr_r <= 13'h0000;
					end else if (!flags_pending_in && tmr_r >= 13'(`WWD_IRQ_LOW_CLKS - 1)) begin
						st_r <= WWD_IRQ_HIGH;
						irq_n_out <= 1'b1;
						tmr_r <= 13'h0000;
					end
				end
				WWD_IRQ_HIGH: begin
					tmr_r <= tmr_r + 13'h0001;
					if (new_flag_in)
						defer_r <= 1'b1;
					if (tmr_r >= 13'(`WWD_IRQ_HIGH_CLKS - 1))
						st_r <= WWD_IRQ_IDLE;
				end
				default: st_r <= WWD_IRQ_IDLE;
			endcase
		end
	end
endmodule // wwd_irq_line

// ### verilog/wwd_window_supervisor.sv
// Window watchdog core: windows, service sources, error counter and interrupt
`timescale 1ns/1ps
`include "wwd_params.svh"
// How it works
// - Service is a trigger-pin falling edge or a command write, per source select.
// - Valid service in open window starts closed window, then a new open window.
// - Valid service decrements error counter if nonzero, no interrupt.
// - Service in closed window: new open window, counter plus two, interrupt.
// - Open window expiry without service: counter plus two, interrupt, new open window.
// - Source selectable; command-write service is the reset default.
// - Window length is base cycle (10 or 100 us) times its count.
// - Error event whenever counter exceeds the configurable threshold.
// - Supervision only while the controller reset output is released.
// - First window after enabling is a 600 ms long open window.
// - Config change during long window restarts with a normal open window.
// - Only falling trigger-pin edges count; rising edges are ignored.
// - Trigger pin is filtered with a 400 us sampling time.
// - Command service is taken at the select rising edge ending a write.
// - New fault flags drive interrupt low; it goes high when the fault flag is cleared.
// - Interrupt low at least 100 us, then high at least 300 us.
// - Low time-out of 300 us releases line and sets missed flag.
module wwd_window_supervisor
	import wwd_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic srst_in,
	// Controller side pins
	input wire logic mcu_reset_out_n_in,
	input wire logic wd_trigger_pin_in,
	input wire logic spi_select_n_in,
	input wire logic wd_service_command_reg_wr_in,
	// Configuration
	input wire logic cfg_write_in,
	input wire logic cfg_pin_source_in,
	input wire logic wd_base_cycle_select_in,
	input wire logic [`WWD_CNT_W-1:0] open_window_cycle_count_in,
	input wire logic [`WWD_CNT_W-1:0] closed_window_cycle_count_in,
	input wire logic [`WWD_ERR_W-1:0] err_threshold_in,
	input wire logic flags_clear_in,
	// Status and pins
	output logic [`WWD_ERR_W-1:0] err_count_out,
	output logic wd_error_out,
	output logic in_open_window_out,
	output logic long_window_out,
	output logic wd_fault_flag_out,
	output logic missed_irq_flag_out,
	output logic irq_n_out
);
	wwd_state_t st_r;
	logic pin_src_r;
	logic cyc_sel_r;
	logic [`WWD_CNT_W-1:0] ow_r;
	logic [`WWD_CNT_W-1:0] cw_r;
	logic [`WWD_ERR_W-1:0] thr_r;
	logic [`WWD_ERR_W-1:0] err_r;
	logic [11:0] base_r;
	logic [`WWD_CNT_W-1:0] ncyc_r;
	logic [23:0] low_r;
	logic long_r;
	logic [2:0] rot_sync_r;
	logic [2:0] wdi_sync_r;
	logic [2:0] scs_sync_r;
	logic [12:0] filt_r;
	logic wdi_filt_r;
	logic wdi_fall_r;
	logic wr_seen_r;
	logic cmd_svc_r;
	logic invalid;
	logic valid;
	logic svc;
	logic base_tick;
	logic irq_missed;
	logic flag_r;
	logic miss_r;

	// Base tick length from the cycle select
	function automatic logic [11:0] wwd_base_len(input logic sel);
		wwd_base_len = sel ? 12'(`WWD_CYC1_CLKS - 1) : 12'(`WWD_CYC0_CLKS - 1);
	endfunction

	// Pin synchronisers; index 0 is read only by index 1
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			rot_sync_r <= 3'h0;
			wdi_sync_r <= 3'h0;
			scs_sync_r <= 3'h7;
		end else begin
			rot_sync_r <= {rot_sync_r[1:0], mcu_reset_out_n_in};
			wdi_sync_r <= {wdi_sync_r[1:0], wd_trigger_pin_in};
			scs_sync_r <= {scs_sync_r[1:0], spi_select_n_in};
		end
	end

	// Trigger pin filter: a level must hold one sampling time to be accepted
	always_ff @(posedge clk_in) begin
		wdi_fall_r <= 1'b0;
		if (srst_in) begin
			filt_r <= 13'h0000;
			wdi_filt_r <= 1'b0;
		end else if (wdi_sync_r[1] == wdi_filt_r) begin
			filt_r <= 13'h0000;
		end else if (filt_r >= 13'(`WWD_FILT_CLKS - 1)) begin
			filt_r <= 13'h0000;
			wdi_filt_r <= wdi_sync_r[1];
			wdi_fall_r <= wdi_filt_r;
		end else begin
			filt_r <= filt_r + 13'h0001;
		end
	end

	// Command service: any write since the last select rising edge, taken at select rising edge
	always_ff @(posedge clk_in) begin
		cmd_svc_r <= 1'b0;
		if (srst_in) begin
			wr_seen_r <= 1'b0;
		end else begin
			if (wd_service_command_reg_wr_in)
				wr_seen_r <= 1'b1;
			if (scs_sync_r[1] && !scs_sync_r[2]) begin
				cmd_svc_r <= wr_seen_r || wd_service_command_reg_wr_in;
				wr_seen_r <= 1'b0;
			end
		end
	end

	assign svc = pin_src_r ? wdi_fall_r : cmd_svc_r;
	assign base_tick = (base_r == 12'h000);
	assign valid = svc && (st_r == WWD_ST_OPEN);
	assign invalid = (svc && st_r == WWD_ST_CLOSED) ||
		(st_r == WWD_ST_OPEN && !long_r && base_tick && ncyc_r == 0 && !svc) ||
		(st_r == WWD_ST_OPEN && long_r && low_r == 24'h000000 && !svc);

	// Configuration; reset default is command service
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			pin_src_r <= 1'b0;
			cyc_sel_r <= 1'b0;
			ow_r <= `WWD_OW_RST;
			cw_r <= `WWD_CW_RST;
			thr_r <= `WWD_THR_RST;
		end else if (cfg_write_in) begin
			pin_src_r <= cfg_pin_source_in;
			cyc_sel_r <= wd_base_cycle_select_in;
			ow_r <= open_window_cycle_count_in;
			cw_r <= closed_window_cycle_count_in;
			thr_r <= err_threshold_in;
		end
	end

	// Window sequencing
	always_ff @(posedge clk_in) begin
		if (srst_in || !rot_sync_r[2]) begin
			st_r <= WWD_ST_OFF;
			long_r <= 1'b0;
			base_r <= 12'h000;
			ncyc_r <= 8'h00;
			low_r <= 24'h000000;
		end else begin
			base_r <= base_tick ? wwd_base_len(cyc_sel_r) : base_r - 12'h001;
			case (st_r)
				WWD_ST_OFF: begin
					st_r <= WWD_ST_OPEN;
					long_r <= 1'b1;
					low_r <= 24'(`WWD_LOW_CLKS - 1);
				end
				WWD_ST_OPEN: begin
					if (long_r)
						low_r <= low_r - 24'h000001;
					else if (base_tick)
						ncyc_r <= ncyc_r - 8'h01;
					if (valid) begin
						st_r <= WWD_ST_CLOSED;
						long_r <= 1'b0;
						base_r <= wwd_base_len(cyc_sel_r);
						ncyc_r <= cw_r - 8'h01;
					end else if (long_r && cfg_write_in) begin
						long_r <= 1'b0;
						// Settings load on this same edge, so take them from the inputs
						base_r <= wwd_base_len(wd_base_cycle_select_in);
						ncyc_r <= open_window_cycle_count_in - 8'h01;
					end else if (invalid) begin
						long_r <= 1'b0;
						base_r <= wwd_base_len(cyc_sel_r);
						ncyc_r <= ow_r - 8'h01;
					end
				end
				WWD_ST_CLOSED: begin
					if (base_tick)
						ncyc_r <= ncyc_r - 8'h01;
					if (invalid || (base_tick && ncyc_r == 0)) begin
						st_r <= WWD_ST_OPEN;
						base_r <= wwd_base_len(cyc_sel_r);
						ncyc_r <= ow_r - 8'h01;
					end
				end
				default: st_r <= WWD_ST_OFF;
			endcase
		end
	end

	// Error counter: up two on invalid, down one on valid, saturating
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			err_r <= 6'h00;
		end else if (invalid) begin
			err_r <= (err_r > 6'(`WWD_ERR_MAX - 2)) ? `WWD_ERR_MAX : err_r + 6'h02;
		end else if (valid && err_r != 6'h00) begin
			err_r <= err_r - 6'h01;
		end
	end

	// Sticky interrupt flags; a new event wins over the clear
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			flag_r <= 1'b0;
			miss_r <= 1'b0;
		end else begin
			flag_r <= invalid || (flag_r && !flags_clear_in);
			miss_r <= irq_missed || (miss_r && !flags_clear_in);
		end
	end

	// Registered status outputs
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			err_count_out <= 6'h00;
			wd_error_out <= 1'b0;
			in_open_window_out <= 1'b0;
			long_window_out <= 1'b0;
			wd_fault_flag_out <= 1'b0;
			missed_irq_flag_out <= 1'b0;
		end else begin
			err_count_out <= err_r;
			wd_error_out <= (err_r > thr_r);
			in_open_window_out <= (st_r == WWD_ST_OPEN);
			long_window_out <= long_r;
			wd_fault_flag_out <= flag_r;
			missed_irq_flag_out <= miss_r;
		end
	end

	// Interrupt pin driver
	wwd_irq_line wwd_irq_line_inst (
		.clk_in(clk_in),
		.srst_in(srst_in),
		.new_flag_in(invalid),
		.flags_pending_in(flag_r),
		.irq_n_out(irq_n_out),
		.missed_out(irq_missed)
	);
endmodule // wwd_window_supervisor

// ### tb/wwd_mcu_model.sv
// Model of the supervised controller driving the service inputs
`timescale 1ns/1ps
module wwd_mcu_model (
	// Clock
	input wire logic clk_in,
	// Service pins
	output logic sel_n_out,
	output logic wr_out,
	output logic trig_out
);
	// Idle levels from time zero
	initial begin
		sel_n_out = 1'b1;
		wr_out = 1'b0;
		trig_out = 1'b1;
	end
	// Command write framed by the select, taken when the select rises
	task automatic service();
		@(posedge clk_in) sel_n_out <= 1'b0;
		@(posedge clk_in) wr_out <= 1'b1;
		@(posedge clk_in) wr_out <= 1'b0;
		@(posedge clk_in) sel_n_out <= 1'b1;
		repeat (8) @(posedge clk_in);
	endtask
	// Trigger pin held low for n cycles, longer than the filter time
	task automatic pin_pulse(input int n);
		@(posedge clk_in) trig_out <= 1'b0;
		repeat (n) @(posedge clk_in);
		trig_out <= 1'b1;
	endtask
endmodule // wwd_mcu_model

// ### tb/wwd_window_supervisor_props.sv
// Property checker for the window supervisor
`timescale 1ns/1ps
`include "wwd_params.svh"
module wwd_chk (
	// Clock, reset and inputs
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic mcu_reset_out_n_in,
	input wire logic cfg_write_in,
	input wire logic [`WWD_ERR_W-1:0] err_threshold_in,
	// Outputs
	input wire logic [`WWD_ERR_W-1:0] err_count_out,
	input wire logic wd_error_out,
	input wire logic in_open_window_out,
	input wire logic long_window_out,
	input wire logic wd_fault_flag_out,
	input wire logic irq_n_out
);
	logic [15:0] low_r;
	logic [5:0] thr_r;
	default clocking @(posedge clk_in); endclocking
	default disable iff (srst_in);
	// Cycles the interrupt line has been low
	always_ff @(posedge clk_in) begin
		low_r <= (srst_in || irq_n_out) ? 16'h0 : low_r + 16'h1;
	end
	// Threshold as last loaded
	always_ff @(posedge clk_in) begin
		thr_r <= srst_in ? `WWD_THR_RST : (cfg_write_in ? err_threshold_in : thr_r);
	end
	sequence s_sup_off;
		!mcu_reset_out_n_in [*6];
	endsequence
	chk_sup_off: assert property (s_sup_off |-> !long_window_out && !in_open_window_out)
		else $error("window active while controller held");
	chk_err_thresh: assert property ((err_count_out > thr_r) [*3] |-> wd_error_out)
		else $error("no error event above threshold");
	chk_err_step: assert property (err_count_out != $past(err_count_out) |->
		err_count_out == $past(err_count_out) + 6'h2 ||
		err_count_out == $past(err_count_out) - 6'h1 || err_count_out == 6'h3f)
		else $error("bad counter step");
	chk_inc_flag: assert property (err_count_out == $past(err_count_out) + 6'h2 |-> ##[0:1]
		wd_fault_flag_out) else $error("increment without fault flag");
	chk_dec_quiet: assert property (err_count_out == $past(err_count_out) - 6'h1
		|-> !$rose(wd_fault_flag_out)) else $error("decrement raised a fault");
	chk_irq_cause: assert property ($fell(irq_n_out) |=> wd_fault_flag_out)
		else $error("interrupt without flag");
	chk_irq_low: assert property ($rose(irq_n_out) |-> $past(low_r) >= 16'h07c6)
		else $error("interrupt low too short");
	chk_irq_tmo: assert property (low_r <= 16'h1775)
		else $error("interrupt low past time-out");
endmodule // wwd_chk
bind wwd_window_supervisor wwd_chk wwd_chk_inst (.clk_in, .srst_in, .mcu_reset_out_n_in,
	.cfg_write_in, .err_threshold_in, .err_count_out, .wd_error_out, .in_open_window_out,
	.long_window_out, .wd_fault_flag_out, .irq_n_out);

// ### tb/wwd_window_supervisor_tb.sv
// Testbench for the window supervisor
`timescale 1ns/1ps
`include "wwd_params.svh"
module wwd_window_supervisor_tb;
	logic clk_in = 1'b0;
	logic srst_in = 1'b1;
	logic mcu_rst_n = 1'b0;
	logic sel_n, wr, trig, wd_err, in_open, long_w, fault, missed, irq_n;
	logic cfg_wr = 1'b0;
	logic clr = 1'b0;
	logic pin_src = 1'b0;
	logic [5:0] err;
	int err_count = 0;
	int total_checks = 0;
	always #25 clk_in = ~clk_in;
	wwd_mcu_model wwd_mcu_model_inst (.clk_in(clk_in), .sel_n_out(sel_n), .wr_out(wr),
		.trig_out(trig));
	wwd_window_supervisor wwd_window_supervisor_inst (.clk_in(clk_in), .srst_in(srst_in),
		.mcu_reset_out_n_in(mcu_rst_n), .wd_trigger_pin_in(trig), .spi_select_n_in(sel_n),
		.wd_service_command_reg_wr_in(wr), .cfg_write_in(cfg_wr), .cfg_pin_source_in(pin_src),
		.wd_base_cycle_select_in(1'b0), .open_window_cycle_count_in(8'h04),
		.closed_window_cycle_count_in(8'h02), .err_threshold_in(6'h03), .flags_clear_in(clr),
		.err_count_out(err), .wd_error_out(wd_err), .in_open_window_out(in_open),
		.long_window_out(long_w), .wd_fault_flag_out(fault), .missed_irq_flag_out(missed),
		.irq_n_out(irq_n));
	// Wait n cycles and settle past the edge
	task automatic wt(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	// Compare and count
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Verdict and end of run
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Main sequence: windows of 800 and 400 cycles, threshold 3
	initial begin
		wt(2);
		@(posedge clk_in) srst_in <= 1'b0;
		wt(10);
		check("long_w", 8'h0, long_w);
		check("irq_n", 8'h1, irq_n);
		@(posedge clk_in) mcu_rst_n <= 1'b1;
		wt(10);
		check("long_w", 8'h1, long_w);
		// Let the filter take the high idle level, then fall on the unselected pin
		wt(8000);
		wwd_mcu_model_inst.pin_pulse(8100);
		wt(20);
		check("long_w", 8'h1, long_w);
		@(posedge clk_in) cfg_wr <= 1'b1;
		@(posedge clk_in) cfg_wr <= 1'b0;
		wt(4);
		check("long_w", 8'h0, long_w);
		check("in_open", 8'h1, in_open);
		wt(50);
		wwd_mcu_model_inst.service();
		wt(1);
		check("in_open", 8'h0, in_open);
		check("err", 8'h0, err);
		wt(100);
		wwd_mcu_model_inst.service();
		wt(1);
		check("err", 8'h2, err);
		check("in_open", 8'h1, in_open);
		check("irq_n", 8'h0, irq_n);
		wt(700);
		check("err", 8'h2, err);
		wt(150);
		check("err", 8'h4, err);
		check("wd_err", 8'h1, wd_err);
		wwd_mcu_model_inst.service();
		wt(1);
		check("err", 8'h3, err);
		check("wd_err", 8'h0, wd_err);
		wt(5300);
		check("missed", 8'h1, missed);
		@(posedge clk_in) clr <= 1'b1;
		@(posedge clk_in) clr <= 1'b0;
		wt(2);
		check("missed", 8'h0, missed);
		// Unserviced windows drive the counter into saturation
		wt(20000);
		check("err", 8'h3f, err);
		check("wd_err", 8'h1, wd_err);
		// Controller held in reset mid-run: supervision stops, then restarts long
		@(posedge clk_in) mcu_rst_n <= 1'b0;
		wt(8);
		check("in_open", 8'h0, in_open);
		check("long_w", 8'h0, long_w);
		@(posedge clk_in) mcu_rst_n <= 1'b1;
		wt(10);
		check("long_w", 8'h1, long_w);
		// Switch to pin service inside the long window
		@(posedge clk_in);
		pin_src <= 1'b1;
		cfg_wr <= 1'b1;
		@(posedge clk_in) cfg_wr <= 1'b0;
		wt(4);
		check("long_w", 8'h0, long_w);
		wwd_mcu_model_inst.pin_pulse(8100);
		wt(1);
		check("in_open", 8'h0, in_open);
		check("err", 8'h3e, err);
		results();
	end
	// Watchdog on the whole run
	initial begin
		#(70000 * 50);
		err_count++;
		results();
	end
endmodule // wwd_window_supervisor_tb
